/* inc/cvs_cfg.svh */
`ifndef CVS_CFG_SVH
`define CVS_CFG_SVH
// register byte offsets
`define CVS_OFF_VHB    12'h000
`define CVS_OFF_CTL    12'h004
`define CVS_OFF_SP     12'h008
`define CVS_OFF_DSTK   12'h00c
`define CVS_OFF_CC     12'h010
`define CVS_OFF_IST    12'h014
`define CVS_OFF_IMSK   12'h018
// field positions
`define CVS_RXSEL_HI   7
`define CVS_RXSEL_LO   6
`define CVS_MASK_HI    4
`define CVS_RSP_HI     7
`define CVS_RSP_LO     4
`define CVS_DPTR_HI    3
`define CVS_CC_Z       0
`define CVS_CC_C       1
`define CVS_CC_V       2
`define CVS_CC_N       3
// reset values
`define CVS_RST_VHB    8'h00
`define CVS_RST_RXSEL  2'h3
`define CVS_RST_MASK   5'h1f
`define CVS_RST_SP     8'h00
`define CVS_RST_CC     4'h0
// six-bit vector codes per source
`define CVS_VEC_NMI    6'h1c
`define CVS_VEC_RX     6'h04
`define CVS_VEC_TX     6'h08
`define CVS_VEC_LTA    6'h0c
`define CVS_VEC_BIDIR  6'h10
`define CVS_VEC_TIMER  6'h14
`endif

/* inc/cvs_pkg.sv */
package cvs_pkg;
    // bus slave phase, one-hot
    typedef enum logic [1:0] {
        CVS_APB_IDLE = 2'b01,
        CVS_APB_RESP = 2'b10
    } cvs_apb_e;
    // vector source select
    typedef enum logic [2:0] {
        CVS_SRC_NMI   = 3'h0,
        CVS_SRC_RX    = 3'h1,
        CVS_SRC_TX    = 3'h2,
        CVS_SRC_LTA   = 3'h3,
        CVS_SRC_BIDIR = 3'h4,
        CVS_SRC_TIMER = 3'h5
    } cvs_src_e;
    // alu instruction class for flag updates
    typedef enum logic [1:0] {
        CVS_OP_ARITH = 2'h0,
        CVS_OP_LOGIC = 2'h1,
        CVS_OP_SHIFT = 2'h2
    } cvs_op_e;
    // receiver interrupt source select codes
    typedef enum logic [1:0] {
        CVS_RX_FULL_ERR = 2'h0,
        CVS_RX_AVAIL_ERR = 2'h1,
        CVS_RX_UNUSED   = 2'h2,
        CVS_RX_ACTIVE   = 2'h3
    } cvs_rxsel_e;
endpackage

/* hw/cvs_core.sv */
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "cvs_cfg.svh"
module cvs_core
    import cvs_pkg::*;
#(
    parameter int STK_DEPTH = 16  // data stack depth in bytes
) (
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    // alu flag update, same clock
    input  wire logic              alu_flag_upd,
    input  wire cvs_pkg::cvs_op_e  alu_class,
    input  wire logic              alu_carry,
    input  wire logic              alu_shift_out,
    input  wire logic              alu_neg,
    input  wire logic              alu_ovf,
    input  wire logic              alu_zero,
    // return stack push and pop from sequencer
    input  wire logic              ret_push,
    input  wire logic              ret_pop,
    // vector request
    input  wire cvs_pkg::cvs_src_e vec_src,
    output logic [15:0]            int_vector,
    // receiver status from transceiver domain
    input  wire logic              rx_fifo_full,
    input  wire logic              rx_err_flag,
    input  wire logic              rx_data_available,
    input  wire logic              rx_active_flag,
    // other maskable requests
    input  wire logic [3:0]        src_req,
    output logic [4:0]             masked_req,
    output logic                   rx_int_req,
    // flag view and event interrupt
    output logic [3:0]             cc_flags,
    output logic                   irq
);
    import cvs_pkg::*;

    // the pointers are four bits, so only a sixteen byte stack fits
    if (STK_DEPTH != 16) begin : g_chk
        $error("cvs_core: STK_DEPTH must be 16");
    end

    // registers
    logic [7:0]          vector_high_byte;   // vector upper bits
    logic [1:0]          rx_int_source_sel;  // receiver source code
    logic [4:0]          int_mask_field;     // set bit blocks source
    logic [3:0]          return_stack_ptr;   // address stack pointer
    logic [3:0]          data_stack_ptr;     // data stack pointer
    logic [7:0]          stk_mem [STK_DEPTH]; // data stack storage
    logic [3:0]          flags;              // n v c z
    logic [3:0]          ev_status;          // sticky events
    logic [3:0]          ev_mask;            // event enables
    cvs_apb_e            apb_state;          // slave phase
    logic [3:0]          rx_s1;              // sync stage one
    logic [3:0]          rx_s2;              // sync stage two
    logic                rx_int_q;           // previous rx request

    // decode
    wire       acc     = psel & penable & (apb_state == CVS_APB_RESP);
    wire       wr_acc  = acc & pwrite;
    wire       rd_acc  = acc & ~pwrite;
    wire       hit_vhb = paddr == `CVS_OFF_VHB;
    wire       hit_ctl  = paddr == `CVS_OFF_CTL;
    wire       hit_sp   = paddr == `CVS_OFF_SP;
    wire       hit_stk  = paddr == `CVS_OFF_DSTK;
    wire       hit_cc   = paddr == `CVS_OFF_CC;
    wire       hit_ist  = paddr == `CVS_OFF_IST;
    wire       hit_msk  = paddr == `CVS_OFF_IMSK;
    wire       hit_any  = hit_vhb | hit_ctl | hit_sp | hit_stk | hit_cc | hit_ist | hit_msk;
    wire       stk_push = wr_acc & hit_stk;
    wire       stk_pop  = rd_acc & hit_stk;
    wire [3:0] dptr_dec = data_stack_ptr - 4'h1;

    // six-bit code per source
    function automatic logic [5:0] vec_code(input cvs_src_e s);
        case (s)
            CVS_SRC_NMI:   vec_code = `CVS_VEC_NMI;
            CVS_SRC_RX:    vec_code = `CVS_VEC_RX;
            CVS_SRC_TX:    vec_code = `CVS_VEC_TX;
            CVS_SRC_LTA:   vec_code = `CVS_VEC_LTA;
            CVS_SRC_BIDIR: vec_code = `CVS_VEC_BIDIR;
            default:       vec_code = `CVS_VEC_TIMER;
        endcase
    endfunction

    // synchronised receiver status: full, err, dav, active
    wire       rx_full = rx_s2[0];
    wire       rx_err  = rx_s2[1];
    wire       rx_avl  = rx_s2[2];
    wire       rx_act  = rx_s2[3];
    wire       next_rx_int = (rx_int_source_sel == CVS_RX_FULL_ERR) ? (rx_full | rx_err) :
                             (rx_int_source_sel == CVS_RX_AVAIL_ERR) ? (rx_avl | rx_err) :
                             (rx_int_source_sel == CVS_RX_ACTIVE)   ? rx_act : 1'b0;
    wire [4:0] all_req = {src_req, next_rx_int};

    // event sources: data stack overflow and underflow, return wrap, rx request rise
    wire [3:0] ev_set = {next_rx_int & ~rx_int_q,
                         (ret_push & ~ret_pop & (return_stack_ptr == 4'hf)) |
                         (ret_pop & ~ret_push & (return_stack_ptr == 4'h0)),
                         stk_pop & (data_stack_ptr == 4'h0),
                         stk_push & (data_stack_ptr == 4'hf)};
    wire [3:0] ev_clr = (wr_acc & hit_ist) ? pwdata[3:0] : 4'h0;

    // read mux
    wire [7:0] rd_byte = hit_vhb ? vector_high_byte :
                         hit_ctl ? {rx_int_source_sel, 1'b0, int_mask_field} :
                         hit_sp  ? {return_stack_ptr, data_stack_ptr} :
                         hit_stk ? stk_mem[dptr_dec] :
                         hit_cc  ? {4'h0, flags} :
                         hit_ist ? {4'h0, ev_status} :
                         hit_msk ? {4'h0, ev_mask} : 8'h00;

    // two flop synchroniser, transceiver runs on its own clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_s1 <= 4'h0;
            rx_s2 <= 4'h0;
        end else begin
            rx_s1 <= {rx_active_flag, rx_data_available, rx_err_flag, rx_fifo_full};
            rx_s2 <= rx_s1;
        end
    end

    // apb phase: one wait state gives registered prdata
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            apb_state <= CVS_APB_IDLE;
            pready    <= 1'b0;
            prdata    <= 32'h0;
            pslverr   <= 1'b0;
        end else begin
            case (apb_state)
                CVS_APB_IDLE: begin
                    pready <= 1'b0;
                    if (psel && penable) begin
                        apb_state <= CVS_APB_RESP;
                        pready    <= 1'b1;
                        prdata    <= pwrite ? 32'h0 : {24'h0, rd_byte};
                        pslverr   <= ~hit_any;
                    end
                end
                default: begin
                    apb_state <= CVS_APB_IDLE;
                    pready    <= 1'b0;
                    pslverr   <= 1'b0;
                end
            endcase
        end
    end

    // control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vector_high_byte  <= `CVS_RST_VHB;
            rx_int_source_sel <= `CVS_RST_RXSEL;
            int_mask_field    <= `CVS_RST_MASK;
            ev_mask           <= 4'h0;
        end else if (wr_acc) begin
            if (hit_vhb) begin
                vector_high_byte <= pwdata[7:0];
            end
            if (hit_ctl) begin
                rx_int_source_sel <= pwdata[`CVS_RXSEL_HI:`CVS_RXSEL_LO];
                int_mask_field    <= pwdata[`CVS_MASK_HI:0];
            end
            if (hit_msk) begin
                ev_mask <= pwdata[3:0];
            end
        end
    end

    // stack pointers: software write replaces, push and pop wrap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            return_stack_ptr <= 4'(`CVS_RST_SP >> 4);
            data_stack_ptr   <= 4'(`CVS_RST_SP);
        end else if (wr_acc && hit_sp) begin
            return_stack_ptr <= pwdata[`CVS_RSP_HI:`CVS_RSP_LO];
            data_stack_ptr   <= pwdata[`CVS_DPTR_HI:0];
        end else begin
            if (ret_push && !ret_pop) begin
                return_stack_ptr <= return_stack_ptr + 4'h1;
            end else if (ret_pop && !ret_push) begin
                return_stack_ptr <= return_stack_ptr - 4'h1;
            end
            if (stk_push) begin
                data_stack_ptr <= data_stack_ptr + 4'h1;
            end else if (stk_pop) begin
                data_stack_ptr <= dptr_dec;
            end
        end
    end

    // stack storage has no reset, content undefined after reset
    always_ff @(posedge pclk) begin
        if (stk_push) begin
            stk_mem[data_stack_ptr] <= pwdata[7:0];
        end
    end

    // condition flags: alu update wins over a software write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= `CVS_RST_CC;
        end else if (alu_flag_upd) begin
            flags[`CVS_CC_N] <= alu_neg;
            flags[`CVS_CC_Z] <= alu_zero;
            if (alu_class == CVS_OP_ARITH) begin
                flags[`CVS_CC_C] <= alu_carry;
                flags[`CVS_CC_V] <= alu_ovf;
            end else if (alu_class == CVS_OP_SHIFT) begin
                flags[`CVS_CC_C] <= alu_shift_out;
            end
        end else if (wr_acc && hit_cc) begin
            flags <= pwdata[3:0];
        end
    end

    // sticky events, set beats write-one-clear
    for (genvar i = 0; i < 4; i++) begin : g_ev
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                ev_status[i] <= 1'b0;
            end else if (ev_set[i]) begin
                ev_status[i] <= 1'b1;
            end else if (ev_clr[i]) begin
                ev_status[i] <= 1'b0;
            end
        end
    end

    // registered outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_vector <= 16'h0;
            masked_req <= 5'h0;
            rx_int_req <= 1'b0;
            rx_int_q   <= 1'b0;
            cc_flags   <= 4'h0;
            irq        <= 1'b0;
        end else begin
            int_vector <= {vector_high_byte, 2'b00, vec_code(vec_src)};
            masked_req <= all_req & ~int_mask_field;
            rx_int_req <= next_rx_int;
            rx_int_q   <= next_rx_int;
            cc_flags   <= flags;
            irq        <= |(ev_status & ev_mask);
        end
    end

    // checks
    AST_VEC: assert property (@(posedge pclk) disable iff (!presetn)
        $past(presetn) |-> int_vector == {$past(vector_high_byte), 2'b00, vec_code($past(vec_src))})
        else $error("vector mismatch");
    AST_NMI: assert property (@(posedge pclk) disable iff (!presetn)
        $past(presetn) && $past(vec_src) == CVS_SRC_NMI |-> int_vector[5:0] == 6'h1c)
        else $error("nmi code wrong");
    AST_RXSEL: assert property (@(posedge pclk) disable iff (!presetn)
        rx_int_source_sel == CVS_RX_UNUSED |=> !rx_int_req)
        else $error("unused rx select raised request");
    AST_PUSH: assert property (@(posedge pclk) disable iff (!presetn)
        stk_push && !(hit_sp && wr_acc) |=> data_stack_ptr == $past(data_stack_ptr) + 4'h1)
        else $error("push did not advance pointer");
    AST_SPWR: assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc && hit_sp |=> {return_stack_ptr, data_stack_ptr} == $past(pwdata[7:0]))
        else $error("pointer write lost");
    AST_CARRY: assert property (@(posedge pclk) disable iff (!presetn)
        alu_flag_upd && alu_class == CVS_OP_SHIFT |=> ##1 cc_flags[1] == $past(alu_shift_out, 2))
        else $error("shift carry wrong");
    AST_OVF: assert property (@(posedge pclk) disable iff (!presetn)
        alu_flag_upd && alu_class == CVS_OP_LOGIC |=> flags[2] == $past(flags[2]))
        else $error("logic op touched overflow");
    AST_MASK: assert property (@(posedge pclk) disable iff (!presetn)
        int_mask_field[0] |=> !masked_req[0])
        else $error("masked source passed");
    AST_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
        ret_push && !ret_pop && return_stack_ptr == 4'hf && !(wr_acc && hit_sp)
        |=> return_stack_ptr == 4'h0)
        else $error("return pointer did not wrap");
    AST_RESP: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready |=> pready)
        else $error("late apb answer");
endmodule

/* testbench/cpu_vector_stack_flag_bits_tb_top.sv */
`timescale 1ns/1ps
module cpu_vector_stack_flag_bits_tb_top;
    import cvs_pkg::*;
    // bus side
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    // alu, stack and receiver side
    logic        alu_flag_upd, alu_carry, alu_shift_out, alu_neg, alu_ovf, alu_zero;
    cvs_op_e     alu_class;
    logic        ret_push, ret_pop, rx_int_req, irq, rxq;
    logic        rx_fifo_full, rx_err_flag, rx_data_available, rx_active_flag;
    cvs_src_e    vec_src;
    logic [3:0]  src_req, cc_flags, fl;
    logic [15:0] int_vector;
    logic [4:0]  masked_req, msk;
    logic [7:0]  vhb;
    logic [7:0]  stk [16];
    logic [1:0]  sel;
    integer      seed, err_total, checks_done;
    // expected low codes per source
    logic [5:0]  vtab [6] = '{6'h1c, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h14};

    cvs_core i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .alu_flag_upd(alu_flag_upd), .alu_class(alu_class), .alu_carry(alu_carry),
        .alu_shift_out(alu_shift_out), .alu_neg(alu_neg), .alu_ovf(alu_ovf),
        .alu_zero(alu_zero), .ret_push(ret_push), .ret_pop(ret_pop), .vec_src(vec_src),
        .int_vector(int_vector), .rx_fifo_full(rx_fifo_full), .rx_err_flag(rx_err_flag),
        .rx_data_available(rx_data_available), .rx_active_flag(rx_active_flag),
        .src_req(src_req), .masked_req(masked_req), .rx_int_req(rx_int_req),
        .cc_flags(cc_flags), .irq(irq)
    );

    // 25 mhz clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // selected receiver condition
    function automatic logic rxexp(logic [1:0] s, logic f, logic e, logic d, logic a);
        rxexp = (s == 2'h0) ? (f | e) : (s == 2'h1) ? (d | e) : (s == 2'h3) ? a : 1'b0;
    endfunction

    // flag model, order {n,v,c,z}; logic ops keep v and c
    function automatic logic [3:0] flexp(logic [3:0] o, cvs_op_e c, logic n, logic v,
                                          logic k, logic so, logic z);
        if (c == CVS_OP_ARITH) begin
            flexp = {n, v, k, z};
        end else if (c == CVS_OP_SHIFT) begin
            flexp = {n, o[2], so, z};
        end else begin
            flexp = {n, o[2], o[1], z};
        end
    endfunction

    // one compare for every kind of result
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        checks_done++;
        if (got !== ex) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic tk(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // apb transfer; waits for pready, never assumes a latency
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        // a slave that never answers counts as a mismatch
        if (pready !== 1'b1) begin
            err_total++;
            $display("MISMATCH apb ready expected 1 seen %b", pready);
        end
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd, er);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] ex);
        apb(1'b0, a, 32'h0, rd, er);
        chk("read data", ex, rd);
        chk("read error", 32'h0, {31'h0, er});
    endtask

    // verdict, the single exit of the run
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // watchdog, far beyond the under one thousand cycles the run needs
    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        close_out;
    end

    initial begin
        seed = 32'hc80d;
        err_total = 0;
        checks_done = 0;
        fl = 4'h0;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {alu_flag_upd, alu_carry, alu_shift_out, alu_neg, alu_ovf, alu_zero} = '0;
        alu_class = CVS_OP_ARITH;
        {ret_push, ret_pop, src_req} = '0;
        {rx_fifo_full, rx_err_flag, rx_data_available, rx_active_flag} = 4'h0;
        vec_src = CVS_SRC_NMI;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        // reset values
        rdc(12'h000, 32'h00);
        rdc(12'h004, 32'hdf);
        rdc(12'h008, 32'h00);
        rdc(12'h010, 32'h00);
        // unmapped place is refused
        apb(1'b0, 12'h01c, 32'h0, rd, er);
        chk("unmapped error", 32'h1, {31'h0, er});
        // high byte, all ones first, then every source
        for (int i = 0; i < 4; i++) begin
            vhb = (i == 0) ? 8'hff : 8'($random(seed));
            wr(12'h000, {24'h0, vhb});
            rdc(12'h000, {24'h0, vhb});
            for (int s = 0; s < 6; s++) begin
                vec_src <= cvs_src_e'(s);
                tk(3);
                chk("vector", {16'h0, vhb, 2'b00, vtab[s]}, {16'h0, int_vector});
            end
        end
        // every receiver select code with random conditions and masks
        for (int i = 0; i < 16; i++) begin
            sel = i[1:0];
            msk = (i < 4) ? 5'h00 : 5'($random(seed));
            wr(12'h004, {24'h0, sel, 1'b0, msk});
            rdc(12'h004, {24'h0, sel, 1'b0, msk});
            {rx_fifo_full, rx_err_flag, rx_data_available, rx_active_flag} <= 4'($random(seed));
            src_req <= 4'($random(seed));
            tk(7);
            rxq = rxexp(sel, rx_fifo_full, rx_err_flag, rx_data_available, rx_active_flag);
            chk("rx request", {31'h0, rxq}, {31'h0, rx_int_req});
            chk("masked", {27'h0, {src_req, rxq} & ~msk}, {27'h0, masked_req});
        end
        // quiet receiver so no stray event, then arm pop event only
        {rx_fifo_full, rx_err_flag, rx_data_available, rx_active_flag} <= 4'h0;
        tk(7);
        wr(12'h014, 32'hff);
        wr(12'h018, 32'h02);
        wr(12'h008, 32'ha5);
        rdc(12'h008, 32'ha5);
        wr(12'h008, 32'h00);
        // fill all sixteen bytes; last push wraps the pointer
        for (int i = 0; i < 16; i++) begin
            stk[i] = 8'($random(seed));
            wr(12'h00c, {24'h0, stk[i]});
        end
        // seventeen return pushes leave the pointer at one
        repeat (17) begin
            ret_push <= 1'b1;
            @(posedge pclk);
            ret_push <= 1'b0;
            @(posedge pclk);
        end
        rdc(12'h008, 32'h10);
        // two pops wrap the return pointer below zero, push with pop holds it
        for (int i = 0; i < 3; i++) begin
            {ret_push, ret_pop} <= (i == 2) ? 2'b11 : 2'b01;
            @(posedge pclk);
            {ret_push, ret_pop} <= 2'b00;
            @(posedge pclk);
        end
        rdc(12'h008, 32'hf0);
        // pops come back newest first, first pop from zero wraps
        for (int i = 15; i >= 0; i--) begin
            rdc(12'h00c, {24'h0, stk[i]});
        end
        tk(2);
        chk("irq", 32'h1, {31'h0, irq});
        rdc(12'h014, 32'h07);
        wr(12'h018, 32'h00);
        tk(2);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(12'h018, 32'h02);
        wr(12'h014, 32'h02);
        tk(2);
        chk("irq cleared", 32'h0, {31'h0, irq});
        rdc(12'h014, 32'h05);
        // software flag write, then random alu updates of all classes
        wr(12'h010, 32'h0a);
        rdc(12'h010, 32'h0a);
        fl = 4'ha;
        for (int i = 0; i < 24; i++) begin
            alu_class <= cvs_op_e'(i % 3);
            {alu_neg, alu_ovf, alu_carry, alu_shift_out, alu_zero} <=
                (i < 3) ? 5'h1f : 5'($random(seed));
            alu_flag_upd <= 1'b1;
            @(posedge pclk);
            alu_flag_upd <= 1'b0;
            fl = flexp(fl, alu_class, alu_neg, alu_ovf, alu_carry, alu_shift_out, alu_zero);
            tk(3);
            chk("flags", {28'h0, fl}, {28'h0, cc_flags});
        end
        rdc(12'h010, {28'h0, fl});
        close_out;
    end
endmodule
